// ==== include/pp_mode_pkg.sv ====
// constants and types for the parallel port mode selection block
// Function
// RULE1: after reset the port runs in extended-capabilities mode
// RULE2: static mode comes from configuration register bits 7 to 5
// RULE3: static field 000 compat, 001 extended, 010 enh 1.7, 011 enh 1.9
// RULE4: run-time change only when config bit 4 set and bits 7-5 are 11x
// RULE5: dynamic mode from extended control bits 7-5 and second control
// RULE6: control field 000 compat, 001 extended, 010 fifo, 011 ecp
// RULE7: control field 100 picks enhanced; second control bit 4 picks rev
// RULE8: second control bit 7 qualifies compatibility in run-time modes; the code only stores and reads back bit 7
// RULE9: software sets config bit 4 before changing control mode bits
// RULE10: second-level registers reached through index 403 and data 404
// RULE11: interrupt routable to lines 1 to 15 except 2 and 13
// RULE12: dma request and acknowledge routable to one of three channels
// RULE13: port active only when function enable bit 4 is set
// RULE14: ecp mode has 16-entry fifo with threshold, pio and dma
// RULE15: standard compatible data path is output only, software driven
// RULE16: fifo compatible mode adds output fifo with hardware handshake
// RULE17: standard extended mode reads and writes full bytes both ways
// RULE18: enhanced 1.7 lacks interlock; others follow full handshake
// RULE19: on reset select-in, feed, strobe, irq float; init driven zero
package pp_mode_pkg;
  localparam logic [10:0] OFS_DATA      = 11'h000;
  localparam logic [10:0] OFS_STATUS    = 11'h001;
  localparam logic [10:0] OFS_CONTROL   = 11'h002;
  localparam logic [10:0] OFS_FIFO      = 11'h400;
  localparam logic [10:0] OFS_EXT_CTRL  = 11'h402;
  localparam logic [10:0] OFS_MODE_IDX  = 11'h403;
  localparam logic [10:0] OFS_MODE_DATA = 11'h404;
  localparam logic [2:0]  IDX_SECOND_CTRL = 3'h2;
  localparam logic [7:0]  RST_CFG       = 8'hF0;
  localparam logic [7:0]  RST_EXT_CTRL  = 8'h60;
  localparam logic [7:0]  RST_CONTROL   = 8'h04;
  localparam logic [7:0]  RST_SECOND    = 8'h00;
  localparam logic [3:0]  RST_IRQ_SEL   = 4'h7;
  localparam logic [1:0]  RST_DMA_SEL   = 2'h0;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          FIFO_WIDTH    = 8;
  localparam logic [4:0]  RST_THRESH    = 5'h08;
  localparam int          HS_CYCLES     = 2;
  typedef enum logic [2:0] {
    MODE_COMPAT, MODE_EXTENDED, MODE_ENH17, MODE_ENH19, MODE_FIFO, MODE_ECP
  } port_mode_e;
  typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_STROBE, HS_WAIT} hs_e;
endpackage

// ==== design/pp_mode_select.sv ====
// parallel port mode selection, register decode, fifo and handshake
`timescale 1ns/1ns
`default_nettype none

module fifo_assisted_compatible_mode #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst_sync_b,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  // honest full and empty from the entry count
  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_ff];
  assign level     = cnt_ff;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // pointers and count; flush empties without touching storage
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else if (flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + AW'(1);
      if (pop) rd_ptr_ff <= rd_ptr_ff + AW'(1);
      if (push && !pop) cnt_ff <= cnt_ff + (AW+1)'(1);
      else if (pop && !push) cnt_ff <= cnt_ff - (AW+1)'(1);
    end
  end
endmodule

module pp_mode_select
  import pp_mode_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [10:0] host_addr,
  input  wire logic        host_rd_b,
  input  wire logic        host_wr_b,
  input  wire logic [7:0]  host_wdata,
  output logic [7:0]       host_rdata,
  input  wire logic [7:0]  cfg_reg,
  input  wire logic        cfg_we,
  input  wire logic        function_enable_reg_one_bit4,
  input  wire logic [3:0]  irq_select,
  input  wire logic [1:0]  dma_select,
  output logic [2:0]       port_mode,
  output logic             port_active,
  input  wire logic [7:0]  pd_in,
  output logic [7:0]       pd_out,
  output logic             pd_oe,
  output logic             data_strobe_out,
  output logic             data_strobe_oe,
  output logic             auto_feed_out,
  output logic             auto_feed_oe,
  output logic             select_in_out,
  output logic             select_in_oe,
  output logic             init_out,
  input  wire logic        ack_b_pin,
  input  wire logic        busy_pin,
  output logic [15:0]      irq_out,
  output logic [15:0]      irq_oe,
  output logic [2:0]       dma_req,
  input  wire logic [2:0]  dma_ack_b
);
  logic [1:0] rst_sync_ff;
  logic       rst_sync_b;
  logic [7:0] cfg_ff;
  logic [7:0] ext_ctrl_ff;
  logic [2:0] mode_idx_ff;
  logic [7:0] second_ctrl_ff;
  logic [7:0] control_ff;
  logic [7:0] data_latch_ff;
  logic [3:0] irq_sel_ff;
  logic [1:0] dma_sel_ff;
  logic       outputs_live_ff;
  logic [2:0] ack_sync_ff;
  logic [2:0] busy_sync_ff;
  logic       ack_seen_ff;
  logic       busy_seen_ff;
  logic       wr_d_ff;
  logic       rd_d_ff;
  logic       wr_pulse;
  logic       rd_pulse;
  logic       dynamic_ok;
  logic       hw_fifo_mode;
  logic       irq_line_ok;
  logic       dma_ack;
  port_mode_e mode;
  hs_e        hs_ff;
  logic [1:0] hs_cnt_ff;
  logic [7:0] fifo_out;
  logic       fifo_valid;
  logic       fifo_ready;
  logic       fifo_pop;
  logic       fifo_push;
  logic [4:0] fifo_level;
  logic       thresh_irq;

  function automatic logic hit(input logic [10:0] a, input logic [10:0] o);
    return a == o;
  endfunction

  function automatic logic mode_is_enh(input port_mode_e m);
    return (m == MODE_ENH17) || (m == MODE_ENH19);
  endfunction

  // two-stage reset release
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) rst_sync_ff <= 2'b00;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_sync_b = rst_sync_ff[1];

  // host strobe edges; strobes are taken as synchronous to core_clk
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wr_d_ff <= 1'b0;
      rd_d_ff <= 1'b0;
    end else begin
      wr_d_ff <= !host_wr_b;
      rd_d_ff <= !host_rd_b;
    end
  end
  assign wr_pulse = !host_wr_b && !wr_d_ff && port_active;
  assign rd_pulse = !host_rd_b && !rd_d_ff && port_active;
  assign port_active = function_enable_reg_one_bit4; // RULE13

  // configuration register image and routing choices
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cfg_ff     <= RST_CFG;
      irq_sel_ff <= RST_IRQ_SEL;
      dma_sel_ff <= RST_DMA_SEL;
    end else if (cfg_we) begin
      cfg_ff     <= cfg_reg; // RULE2
      irq_sel_ff <= irq_select;
      dma_sel_ff <= dma_select;
    end
  end

  assign dynamic_ok = cfg_ff[4] && (cfg_ff[7:6] == 2'b11); // RULE4

  // extended control register; host writes change mode bits only when dynamic, a static config write resets them
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ext_ctrl_ff <= RST_EXT_CTRL; // RULE1
    end else if (cfg_we && !(cfg_reg[4] && cfg_reg[7:6] == 2'b11)) begin
      ext_ctrl_ff[7:5] <= RST_EXT_CTRL[7:5]; // RULE4
    end else if (wr_pulse && hit(host_addr, OFS_EXT_CTRL)) begin
      ext_ctrl_ff[4:0] <= host_wdata[4:0];
      if (dynamic_ok) ext_ctrl_ff[7:5] <= host_wdata[7:5]; // RULE9
    end
  end

  // indirect second-level registers
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mode_idx_ff    <= 3'h0;
      second_ctrl_ff <= RST_SECOND;
    end else if (wr_pulse && hit(host_addr, OFS_MODE_IDX)) begin
      mode_idx_ff <= host_wdata[2:0]; // RULE10
    end else if (wr_pulse && hit(host_addr, OFS_MODE_DATA) &&
                 mode_idx_ff == IDX_SECOND_CTRL) begin
      second_ctrl_ff <= host_wdata; // RULE10
    end
  end

  // mode decode, static or run-time
  always_comb begin
    mode = MODE_ECP;
    if (!dynamic_ok) begin
      case (cfg_ff[7:5]) // RULE3
        3'b000:  mode = MODE_COMPAT;
        3'b001:  mode = MODE_EXTENDED;
        3'b010:  mode = MODE_ENH17;
        3'b011:  mode = MODE_ENH19;
        default: mode = MODE_ECP;
      endcase
    end else begin
      case (ext_ctrl_ff[7:5]) // RULE5 RULE6
        3'b000:  mode = MODE_COMPAT;
        3'b001:  mode = MODE_EXTENDED;
        3'b010:  mode = MODE_FIFO;
        3'b011:  mode = MODE_ECP;
        3'b100:  mode = second_ctrl_ff[4] ? MODE_ENH19 : MODE_ENH17; // RULE7
        default: mode = MODE_ECP;
      endcase
    end
  end
  assign port_mode    = 3'(mode);
  assign hw_fifo_mode = (mode == MODE_FIFO) || (mode == MODE_ECP);

  // data latch and standard control register
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      data_latch_ff <= 8'h00;
      control_ff    <= RST_CONTROL;
    end else if (wr_pulse && hit(host_addr, OFS_DATA)) begin
      data_latch_ff <= host_wdata; // RULE15 RULE17
    end else if (wr_pulse && hit(host_addr, OFS_CONTROL)) begin
      control_ff <= host_wdata;
      // compat modes keep the direction bit clear
      if (mode != MODE_EXTENDED && mode != MODE_ECP && !mode_is_enh(mode))
        control_ff[5] <= 1'b0; // RULE15
    end
  end

  // outputs other than init stay floating from reset until software first writes control
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) outputs_live_ff <= 1'b0; // RULE19
    else if (wr_pulse && hit(host_addr, OFS_CONTROL)) outputs_live_ff <= 1'b1;
  end

  // three-stage input samplers; change counts when stages two and three agree
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ack_sync_ff  <= 3'b111;
      busy_sync_ff <= 3'b000;
      ack_seen_ff  <= 1'b1;
      busy_seen_ff <= 1'b0;
    end else begin
      ack_sync_ff  <= {ack_sync_ff[1:0], ack_b_pin};
      busy_sync_ff <= {busy_sync_ff[1:0], busy_pin};
      if (ack_sync_ff[2] == ack_sync_ff[1]) ack_seen_ff <= ack_sync_ff[2];
      if (busy_sync_ff[2] == busy_sync_ff[1]) busy_seen_ff <= busy_sync_ff[2];
    end
  end

  // fifo writes from host or dma; a full fifo drops a host write and withdraws the dma request
  assign dma_ack   = (dma_sel_ff != 2'h3) && !dma_ack_b[dma_sel_ff];
  assign fifo_push = hw_fifo_mode && ((wr_pulse && hit(host_addr, OFS_FIFO))
                     || dma_ack); // RULE14 RULE16

  fifo_assisted_compatible_mode #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk   (core_clk),
    .rst_sync_b (rst_sync_b),
    .flush      (!hw_fifo_mode),
    .in_data    (host_wdata),
    .in_valid   (fifo_push),
    .in_ready   (fifo_ready),
    .out_data   (fifo_out),
    .out_valid  (fifo_valid),
    .out_ready  (fifo_pop),
    .level      (fifo_level)
  );

  // hardware handshake drains the fifo; printer busy stalls it
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hs_ff     <= HS_IDLE;
      hs_cnt_ff <= 2'h0;
    end else begin
      case (hs_ff)
        HS_IDLE: begin
          if (fifo_valid && !busy_seen_ff) hs_ff <= HS_SETUP; // RULE16
        end
        HS_SETUP: begin
          hs_ff     <= HS_STROBE;
          hs_cnt_ff <= 2'(HS_CYCLES);
        end
        HS_STROBE: begin
          // strobe stays low until busy answers; a printer that never
          // raises busy stalls the fifo, the price of the interlock
          if (hs_cnt_ff <= 2'h1 &&
              (mode == MODE_ENH17 || busy_seen_ff)) // RULE18
            hs_ff <= HS_WAIT;
          if (hs_cnt_ff != 2'h0) hs_cnt_ff <= hs_cnt_ff - 2'h1;
        end
        HS_WAIT: begin
          // interlock on busy except in the uninterlocked enhanced mode
          if (mode == MODE_ENH17 || !busy_seen_ff) // RULE18
            hs_ff <= HS_IDLE;
        end
        default: hs_ff <= HS_IDLE;
      endcase
    end
  end
  assign fifo_pop = (hs_ff == HS_WAIT) && hw_fifo_mode &&
                    (mode == MODE_ENH17 || !busy_seen_ff);

  // threshold interrupt and demand dma request
  assign thresh_irq = hw_fifo_mode && !ext_ctrl_ff[2] &&
                      (fifo_level < RST_THRESH); // RULE14
  assign irq_line_ok = (irq_sel_ff != 4'h0) && (irq_sel_ff != 4'h2) &&
                       (irq_sel_ff != 4'hD); // RULE11

  // interrupt lines: only the routed line is driven
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_irq
      assign irq_oe[gi]  = outputs_live_ff && irq_line_ok &&
                           (irq_sel_ff == 4'(gi)); // RULE11 RULE19
      assign irq_out[gi] = thresh_irq || (control_ff[4] && !ack_seen_ff);
    end
    for (gi = 0; gi < 3; gi++) begin : g_dma
      assign dma_req[gi] = (dma_sel_ff == 2'(gi)) && ext_ctrl_ff[3] &&
                           hw_fifo_mode && fifo_ready; // RULE12
    end
  endgenerate

  // pins: strobe from software or from the handshake machine
  assign data_strobe_out = hw_fifo_mode ? !(hs_ff == HS_STROBE)
                                        : !control_ff[0];
  assign data_strobe_oe  = outputs_live_ff; // RULE19
  assign auto_feed_out   = !control_ff[1];
  assign auto_feed_oe    = outputs_live_ff; // RULE19
  assign select_in_out   = !control_ff[3];
  assign select_in_oe    = outputs_live_ff; // RULE19
  assign init_out        = outputs_live_ff && control_ff[2]; // RULE19
  assign pd_out = hw_fifo_mode ? fifo_out : data_latch_ff;
  assign pd_oe  = outputs_live_ff &&
                  (mode == MODE_COMPAT || mode == MODE_FIFO ||
                   !control_ff[5]); // RULE15 RULE17

  // register read-back; bit 7 of second control shown with its index
  always_comb begin
    host_rdata = 8'h00;
    if (hit(host_addr, OFS_DATA))
      host_rdata = (mode == MODE_EXTENDED && control_ff[5]) ? pd_in
                   : data_latch_ff; // RULE17
    else if (hit(host_addr, OFS_STATUS))
      host_rdata = {!busy_seen_ff, ack_seen_ff, 6'h3F};
    else if (hit(host_addr, OFS_CONTROL))
      host_rdata = control_ff;
    else if (hit(host_addr, OFS_EXT_CTRL))
      host_rdata = {ext_ctrl_ff[7:2], fifo_level == 5'(FIFO_DEPTH),
                    fifo_level == 5'h00};
    else if (hit(host_addr, OFS_MODE_IDX))
      host_rdata = {5'h00, mode_idx_ff};
    else if (hit(host_addr, OFS_MODE_DATA) && mode_idx_ff == IDX_SECOND_CTRL)
      host_rdata = second_ctrl_ff; // RULE8
  end
endmodule

`default_nettype wire

// ==== dv/pp_mode_checker.sv ====
// concurrent checks on the mode selection block ports
`timescale 1ns/1ns
`default_nettype none
module pp_mode_checker
  import pp_mode_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic [10:0] host_addr,
  input wire logic        host_wr_b,
  input wire logic [7:0]  host_wdata,
  input wire logic [7:0]  cfg_reg,
  input wire logic        cfg_we,
  input wire logic        function_enable_reg_one_bit4,
  input wire logic [2:0]  port_mode,
  input wire logic        port_active,
  input wire logic        data_strobe_oe,
  input wire logic        auto_feed_oe,
  input wire logic        select_in_oe,
  input wire logic        init_out,
  input wire logic [15:0] irq_oe,
  input wire logic [2:0]  dma_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  chk_reset_float: assert property (
    $rose(rst_b) |-> !data_strobe_oe && !auto_feed_oe && !select_in_oe
    && irq_oe == 16'h0000 && !init_out)
    else $error("handshake outputs driven right after reset");
  chk_ecp_default: assert property (
    $rose(rst_b) |-> port_mode == 3'h5)
    else $error("mode after reset is not ecp");
  chk_static_mode: assert property (
    cfg_we && !cfg_reg[7] ##1 (!cfg_we && $stable(cfg_reg)) [*2]
    |-> port_mode == {1'b0, cfg_reg[6:5]})
    else $error("static mode does not follow config field");
  chk_static_locked: assert property (
    (!cfg_reg[7] && !cfg_we) [*4] ##0
    ($fell(host_wr_b) && host_addr == OFS_EXT_CTRL)
    |=> $stable(port_mode) [*2])
    else $error("static mode changed by control write");
  chk_ecr_fifo: assert property (
    $fell(host_wr_b) && host_addr == OFS_EXT_CTRL && port_active
    && host_wdata[7:5] == 3'b010 && cfg_reg[7:6] == 2'b11 && cfg_reg[4]
    |=> port_mode == 3'h4)
    else $error("fifo mode not entered");
  chk_inactive_drop: assert property (
    !port_active && !cfg_we && $fell(host_wr_b) |=> $stable(port_mode))
    else $error("write taken while port inactive");
  chk_active_rise: assert property (
    $rose(function_enable_reg_one_bit4) |-> ##[0:2] port_active)
    else $error("port not activated");
  chk_active_fall: assert property (
    $fell(function_enable_reg_one_bit4) |-> ##[0:2] !port_active)
    else $error("port not deactivated");
  chk_irq_single: assert property (
    $onehot0(irq_oe) && !irq_oe[0] && !irq_oe[2] && !irq_oe[13])
    else $error("illegal interrupt line driven");
  chk_dma_single: assert property (
    $onehot0(dma_req))
    else $error("more than one dma request");
endmodule
`default_nettype wire

// ==== dv/printer_model.sv ====
// printer-side model answering the strobe handshake
`timescale 1ns/1ns
`default_nettype none
module printer_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] pd_out,
  input  wire logic       data_strobe_out,
  input  wire logic       data_strobe_oe,
  input  wire logic       stall,
  output logic            ack_b_pin,
  output logic            busy_pin
);
  logic [7:0] got_q[$];
  logic       working = 1'b0;
  // busy while stalled, so the fifo backs up behind us
  assign busy_pin = stall | working;
  initial ack_b_pin = 1'b1;
  // latch on strobe, then ack once the stall lifts
  always @(negedge data_strobe_out) begin
    if (data_strobe_oe) begin
      got_q.push_back(pd_out);
      @(posedge core_clk) #1;
      working = 1'b1;
      repeat (3) @(posedge core_clk);
      wait (!stall);
      @(posedge core_clk) #1;
      ack_b_pin = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      ack_b_pin = 1'b1;
      working = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== dv/parallel_port_mode_select_tb.sv ====
// self-checking bench for the parallel port mode selection block
`timescale 1ns/1ns
`default_nettype none
module parallel_port_mode_select_tb
  import pp_mode_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [10:0] host_addr = 11'h000;
  logic        host_rd_b = 1'b1;
  logic        host_wr_b = 1'b1;
  logic [7:0]  host_wdata = 8'h00;
  logic [7:0]  cfg_reg = 8'hF0;
  logic        cfg_we = 1'b0;
  logic        function_enable_reg_one_bit4 = 1'b1;
  logic [3:0]  irq_select = 4'h7;
  logic [1:0]  dma_select = 2'h0;
  logic        stall = 1'b0;
  logic [2:0]  dma_ack_b = 3'h7;
  logic [7:0]  host_rdata, pd_in, pd_out;
  logic [2:0]  port_mode, dma_req;
  logic [15:0] irq_out, irq_oe;
  logic        port_active, pd_oe, data_strobe_out, data_strobe_oe;
  logic        auto_feed_out, auto_feed_oe, select_in_out, select_in_oe;
  logic        init_out, ack_b_pin, busy_pin;
  logic [3:0]  ctl_pins;
  int          failures = 0;
  int          samples_checked = 0;

  always #25 core_clk = ~core_clk;
  // far side floats the data lines to a fixed pattern when we release them
  assign pd_in = pd_oe ? pd_out : 8'hC3;
  // control pin levels seen together
  assign ctl_pins = {init_out, select_in_out, auto_feed_out, data_strobe_out};

  pp_mode_select i_dut (
    .core_clk, .rst_b, .host_addr, .host_rd_b, .host_wr_b, .host_wdata,
    .host_rdata, .cfg_reg, .cfg_we, .function_enable_reg_one_bit4,
    .irq_select, .dma_select, .port_mode, .port_active, .pd_in, .pd_out,
    .pd_oe, .data_strobe_out, .data_strobe_oe, .auto_feed_out,
    .auto_feed_oe, .select_in_out, .select_in_oe, .init_out, .ack_b_pin,
    .busy_pin, .irq_out, .irq_oe, .dma_req, .dma_ack_b);
  printer_model i_prn (
    .core_clk, .pd_out, .data_strobe_out, .data_strobe_oe, .stall,
    .ack_b_pin, .busy_pin);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    host_addr = a;
    host_wdata = d;
    host_wr_b = 1'b0;
    @(posedge core_clk) #1;
    host_wr_b = 1'b1;
  endtask
  task automatic rd(input logic [10:0] a, output logic [7:0] d);
    @(posedge core_clk) #1;
    host_addr = a;
    host_rd_b = 1'b0;
    @(posedge core_clk);
    d = host_rdata;
    #1;
    host_rd_b = 1'b1;
  endtask
  // routing selects are loaded with the same strobe
  task automatic load_cfg(input logic [7:0] v);
    @(posedge core_clk) #1;
    cfg_reg = v;
    cfg_we = 1'b1;
    @(posedge core_clk) #1;
    cfg_we = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic t_static();
    for (int m = 0; m < 4; m++) begin
      load_cfg({1'b0, m[1:0], 5'h00});
      check(port_mode, m[2:0]);
      wr(OFS_EXT_CTRL, 8'h40);
      check(port_mode, m[2:0]);
    end
    $display("static modes done");
  endtask
  task automatic t_dynamic();
    logic [2:0] ecr_exp [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
    logic [7:0] d;
    load_cfg(8'hF0);
    check(port_mode, 3'h5);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_EXT_CTRL, {i[2:0], 5'h00});
      check(port_mode, ecr_exp[i]);
    end
    rd(OFS_EXT_CTRL, d);
    check(d[7:5], 3'h3);
    wr(OFS_MODE_IDX, {5'h00, IDX_SECOND_CTRL});
    for (int b = 0; b < 2; b++) begin
      wr(OFS_MODE_DATA, {b[0], 2'h0, b[0], 4'h0});
      rd(OFS_MODE_DATA, d);
      check({d[7], d[4]}, {b[0], b[0]});
      wr(OFS_EXT_CTRL, 8'h80);
      check(port_mode, 3'h2 + b[2:0]);
    end
    load_cfg(8'hE0);
    wr(OFS_EXT_CTRL, 8'h20);
    check(port_mode, 3'h5);
    $display("run-time modes done");
  endtask
  task automatic t_active();
    load_cfg(8'hF0);
    function_enable_reg_one_bit4 = 1'b0;
    wr(OFS_EXT_CTRL, 8'h20);
    check({port_active, port_mode}, 4'h5);
    function_enable_reg_one_bit4 = 1'b1;
    wr(OFS_EXT_CTRL, 8'h20);
    check({port_active, port_mode}, 4'h9);
    $display("activation done");
  endtask
  task automatic t_route();
    wr(OFS_CONTROL, 8'h04);
    wr(OFS_EXT_CTRL, 8'h68);
    for (int q = 1; q < 16; q++) begin
      if (q == 2 || q == 13)
        continue;
      irq_select = q[3:0];
      dma_select = 2'(q % 3);
      load_cfg(8'hF0);
      check(irq_oe, 16'h0001 << q);
      check(irq_out[q], 1'b1);
      check(dma_req, 3'h1 << (q % 3));
    end
    irq_select = 4'hD;
    load_cfg(8'hF0);
    check(irq_oe, 16'h0000);
    $display("routing done");
  endtask
  task automatic t_fifo();
    logic [7:0] d;
    stall = 1'b1;
    wr(OFS_CONTROL, 8'h04);
    wr(OFS_EXT_CTRL, 8'h40);
    check(port_mode, 3'h4);
    for (int k = 0; k < 17; k++)
      wr(OFS_FIFO, 8'hA0 + k[7:0]);
    rd(OFS_EXT_CTRL, d);
    check(d[1], 1'b1);
    stall = 1'b0;
    for (int k = 0; k < 2000 && d[0] !== 1'b1; k++)
      rd(OFS_EXT_CTRL, d);
    check(d[0], 1'b1);
    repeat (20) @(posedge core_clk);
    check(16'(i_prn.got_q.size()), 16'h0010);
    for (int k = 0; k < 16 && k < i_prn.got_q.size(); k++)
      check(i_prn.got_q[k], 8'hA0 + k[7:0]);
    $display("fifo drain done");
  endtask
  task automatic t_data();
    logic [7:0] d;
    wr(OFS_EXT_CTRL, 8'h00);
    wr(OFS_DATA, 8'h5A);
    wr(OFS_CONTROL, 8'h24);
    check({pd_oe, pd_out}, 9'h15A);
    check(ctl_pins, 4'hF);
    rd(OFS_DATA, d);
    check(d, 8'h5A);
    wr(OFS_CONTROL, 8'h0B);
    check(ctl_pins, 4'h0);
    wr(OFS_EXT_CTRL, 8'h20);
    wr(OFS_CONTROL, 8'h24);
    rd(OFS_DATA, d);
    check({pd_oe, d}, 9'h0C3);
    $display("data path done");
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    check({init_out, data_strobe_oe, auto_feed_oe, select_in_oe}, 4'h0);
    check(irq_oe, 16'h0000);
    repeat (2) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check(port_mode, 3'h5);
    t_static();
    t_dynamic();
    t_active();
    t_route();
    t_fifo();
    t_data();
    wrap_up();
  end
  // cut a hang short
  initial begin
    #1000000;
    failures++;
    wrap_up();
  end
endmodule

bind pp_mode_select pp_mode_checker i_chk (
  .core_clk, .rst_b, .host_addr, .host_wr_b, .host_wdata, .cfg_reg,
  .cfg_we, .function_enable_reg_one_bit4, .port_mode, .port_active,
  .data_strobe_oe, .auto_feed_oe, .select_in_oe, .init_out, .irq_oe,
  .dma_req);
`default_nettype wire
